//--- design/tcspi_defines.svh
// offsets, field positions and reset values of the thermocouple serial register port
`ifndef TCSPI_DEFINES_SVH
`define TCSPI_DEFINES_SVH
`define TCSPI_REG_COUNT        16
`define TCSPI_ADDR_WIDTH       7
`define TCSPI_ADDR_WRITE_BIT   7
`define TCSPI_ADDR_CFG_PRI     4'h0
`define TCSPI_ADDR_CFG_SEC     4'h1
`define TCSPI_ADDR_FMASK       4'h2
`define TCSPI_ADDR_COLD_HI     4'h3
`define TCSPI_ADDR_COLD_LO     4'h4
`define TCSPI_ADDR_LIN_HI_MSB  4'h5
`define TCSPI_ADDR_LIN_HI_LSB  4'h6
`define TCSPI_ADDR_LIN_LO_MSB  4'h7
`define TCSPI_ADDR_LIN_LO_LSB  4'h8
`define TCSPI_ADDR_COLD_OFS    4'h9
`define TCSPI_ADDR_COLD_MSB    4'hA
`define TCSPI_ADDR_COLD_LSB    4'hB
`define TCSPI_ADDR_LIN_B2      4'hC
`define TCSPI_ADDR_LIN_B1      4'hD
`define TCSPI_ADDR_LIN_B0      4'hE
`define TCSPI_ADDR_FLAGS       4'hF
`define TCSPI_RST_CFG_PRI      8'h00
`define TCSPI_RST_CFG_SEC      8'h03
`define TCSPI_RST_FMASK        8'hFF
`define TCSPI_RST_COLD_HI      8'h7F
`define TCSPI_RST_COLD_LO      8'hC0
`define TCSPI_RST_LIN_HI_MSB   8'h7F
`define TCSPI_RST_LIN_HI_LSB   8'hFF
`define TCSPI_RST_LIN_LO_MSB   8'h80
`define TCSPI_RST_LIN_LO_LSB   8'h00
`define TCSPI_RST_ZERO         8'h00
`define TCSPI_UNMAPPED_BYTE    8'hFF
`define TCSPI_BIT_CONT_CONV    7
`define TCSPI_BIT_SINGLE_REQ   6
`define TCSPI_BIT_OPEN_HI      5
`define TCSPI_BIT_OPEN_LO      4
`define TCSPI_BIT_COLD_DIS     3
`define TCSPI_BIT_FAULT_MODE   2
`define TCSPI_BIT_FLAG_CLEAR   1
`define TCSPI_BIT_NOTCH_SEL    0
`define TCSPI_BIT_COLD_RANGE   7
`define TCSPI_BIT_HOT_RANGE    6
`endif

//--- design/tcspi_pkg.sv
// types shared by the thermocouple serial register port
package tcspi_pkg;
   typedef logic [7:0] tcspi_byte_t;
   typedef enum logic [1:0] {TCSPI_IDLE, TCSPI_ADDR, TCSPI_READ, TCSPI_WRITE} tcspi_phase_t;
endpackage

//--- design/tcspi_if.sv
// link between the port controller and its bit shifter
interface tcspi_if;
   import tcspi_pkg::*;
   logic        strobe;
   logic        shift;
   logic        sdi_bit;
   logic        frame;
   logic        load;
   tcspi_byte_t tx_byte;
   tcspi_byte_t rx_byte;
   logic        byte_done;
   logic        sdo_bit;
   modport ctrl (output strobe, shift, sdi_bit, frame, load, tx_byte,
                 input rx_byte, byte_done, sdo_bit);
   modport shifter (input strobe, shift, sdi_bit, frame, load, tx_byte,
                    output rx_byte, byte_done, sdo_bit);
endinterface

//--- design/tcspi_sync.sv
// two-stage synchroniser for pin inputs
module tcspi_sync #(
   parameter int   WIDTH     = 1,
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         stage1 <= {WIDTH{RESET_VAL}};
         q_out  <= {WIDTH{RESET_VAL}};
      end
      else
      begin
         stage1 <= d_in;
         q_out  <= stage1;
      end
   end
endmodule

//--- design/tcspi_shifter.sv
// serial byte shifter: msb-first in on strobe, msb-first out on shift
module tcspi_shifter (
   input wire logic clk_sys,
   input wire logic resetn,
   tcspi_if.shifter lnk
);
   import tcspi_pkg::*;
   logic [2:0]  bit_cnt;
   tcspi_byte_t rx_shift;
   tcspi_byte_t tx_shift;
   wire         last_bit = (bit_cnt == 3'h7);
   wire tcspi_byte_t rx_full = {rx_shift[6:0], lnk.sdi_bit};

   always_ff @(posedge clk_sys)
   begin
      if (!resetn || !lnk.frame)
      begin
         // partial byte dropped when the frame ends
         bit_cnt       <= 3'h0; // RQ21
         rx_shift      <= 8'h00;
         lnk.byte_done <= 1'b0;
      end
      else
      begin
         lnk.byte_done <= lnk.strobe && last_bit; // RQ9
         if (lnk.strobe)
         begin
            rx_shift <= rx_full;
            bit_cnt  <= bit_cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         lnk.rx_byte <= 8'h00;
         tx_shift    <= 8'h00;
         lnk.sdo_bit <= 1'b0;
      end
      else
      begin
         if (lnk.strobe && last_bit)
            lnk.rx_byte <= rx_full;
         if (lnk.load)
            tx_shift <= lnk.tx_byte;
         else if (lnk.shift)
         begin
            lnk.sdo_bit <= tx_shift[7]; // RQ9
            tx_shift    <= {tx_shift[6:0], 1'b0};
         end
      end
   end
endmodule

//--- design/tcspi_port.sv
// serial register port of the thermocouple converter, with result-ready and range flags
`include "tcspi_defines.svh"

// Summary of operation
// RQ1: flag bits 7/6 mark cold/hot out-of-range
// RQ2: out-of-range hot result saturates at limit
// RQ3: range flags never pull the fault output
// RQ4: chip select frames; idle: inputs ignored, hi-Z
// RQ5: master toggles clock only inside a frame
// RQ6: clock level at frame start sets idle polarity
// RQ7: latch on strobe edge, shift on other
// RQ8: master uses clock phase one
// RQ9: one clock per bit, bytes msb first
// RQ10: first byte is address; bit 7 selects write
// RQ11: address advances per byte, wraps at top
// RQ12: unmapped addresses read as all ones
// RQ13: writes to read-only registers are dropped
// RQ14: output hi-Z until a full byte is ready
// RQ15: new linearized result drives ready low
// RQ16: reading result or enabled cold registers releases ready
// RQ17: sixteen byte registers, write address has bit 7
// RQ18: primary config field layout, bit 7 down to 0
// RQ19: single conversion starts at frame end, bit self-clears
// RQ20: master reads three result bytes in one burst
// RQ21: write per complete byte; partial byte discarded
module tcspi_port (
   input  wire logic               clk_sys,
   input  wire logic               resetn,
   input  wire logic               sclk,
   input  wire logic               cs_n,
   input  wire logic               sdi,
   output logic                    sdo,
   output logic                    sdo_oe_n,
   output logic                    result_ready_n,
   output logic                    fault_n,
   input  wire logic               lin_result_valid,
   input  wire logic [23:0]        lin_result,
   input  wire logic               hot_out_of_range,
   input  wire logic [23:0]        hot_limit_high,
   input  wire logic [23:0]        hot_limit_low,
   input  wire logic               cold_result_valid,
   input  wire logic [15:0]        cold_result,
   input  wire logic               cold_out_of_range,
   input  wire logic [5:0]         fault_cond,
   output tcspi_pkg::tcspi_byte_t  config_primary,
   output tcspi_pkg::tcspi_byte_t  config_secondary,
   output tcspi_pkg::tcspi_byte_t  fault_mask,
   output logic                    single_convert_start
);
   import tcspi_pkg::*;

   localparam tcspi_byte_t RESET_VALS [`TCSPI_REG_COUNT] = '{
      `TCSPI_RST_CFG_PRI,    `TCSPI_RST_CFG_SEC,    `TCSPI_RST_FMASK,      `TCSPI_RST_COLD_HI,
      `TCSPI_RST_COLD_LO,    `TCSPI_RST_LIN_HI_MSB, `TCSPI_RST_LIN_HI_LSB, `TCSPI_RST_LIN_LO_MSB,
      `TCSPI_RST_LIN_LO_LSB, `TCSPI_RST_ZERO,       `TCSPI_RST_ZERO,       `TCSPI_RST_ZERO,
      `TCSPI_RST_ZERO,       `TCSPI_RST_ZERO,       `TCSPI_RST_ZERO,       `TCSPI_RST_ZERO};

   tcspi_if lnk ();

   logic [2:0]                   pins_sync;
   logic                         sclk_s;
   logic                         cs_n_s;
   logic                         sdi_s;
   logic                         sclk_prev;
   logic                         cs_n_prev;
   logic                         idle_high;
   tcspi_phase_t                 phase;
   tcspi_phase_t                 next_phase;
   logic [`TCSPI_ADDR_WIDTH-1:0] addr;
   logic [`TCSPI_ADDR_WIDTH-1:0] next_addr;
   tcspi_byte_t                  regs      [`TCSPI_REG_COUNT];
   tcspi_byte_t                  next_regs [`TCSPI_REG_COUNT];
   tcspi_byte_t                  next_flags;

   // cs_n resets high so an idle bus never looks like a frame start
   tcspi_sync #(
      .WIDTH     (3),
      .RESET_VAL (1'b1)
   ) u_sync (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .d_in    ({sclk, cs_n, sdi}),
      .q_out   (pins_sync)
   );

   assign sclk_s = pins_sync[2];
   assign cs_n_s = pins_sync[1];
   assign sdi_s  = pins_sync[0];

   tcspi_shifter u_shifter (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .lnk     (lnk)
   );

   // frame and clock edge decode
   wire in_frame    = !cs_n_s; // RQ4
   wire frame_start = cs_n_prev && !cs_n_s;
   wire frame_end   = !cs_n_prev && cs_n_s;
   wire sclk_rise   = sclk_s && !sclk_prev;
   wire sclk_fall   = !sclk_s && sclk_prev;
   wire strobe_edge = in_frame && (idle_high ? sclk_rise : sclk_fall); // RQ7
   wire shift_edge  = in_frame && (idle_high ? sclk_fall : sclk_rise); // RQ7

   assign lnk.frame   = in_frame;
   assign lnk.strobe  = strobe_edge;
   assign lnk.shift   = shift_edge && (phase == TCSPI_READ);
   assign lnk.sdi_bit = sdi_s;

   // byte events
   wire addr_done = lnk.byte_done && (phase == TCSPI_ADDR);
   wire rd_done   = lnk.byte_done && (phase == TCSPI_READ);
   wire wr_done   = lnk.byte_done && (phase == TCSPI_WRITE);
   wire wr_mode   = lnk.rx_byte[`TCSPI_ADDR_WRITE_BIT]; // RQ10

   // read prefetch: next byte is fetched as the previous one completes
   wire [`TCSPI_ADDR_WIDTH-1:0] fetch_addr = addr_done ? lnk.rx_byte[`TCSPI_ADDR_WIDTH-1:0]
                                                       : addr + 7'h01; // RQ11
   wire        fetch_mapped = (fetch_addr < 7'(`TCSPI_REG_COUNT));
   wire [3:0]  fetch_idx    = fetch_addr[3:0];
   wire tcspi_byte_t fetch_byte = fetch_mapped ? regs[fetch_idx]
                                               : `TCSPI_UNMAPPED_BYTE; // RQ12

   assign lnk.load    = (addr_done && !wr_mode) || rd_done; // RQ14
   assign lnk.tx_byte = fetch_byte;

   // write decode
   wire        addr_mapped = (addr < 7'(`TCSPI_REG_COUNT));
   wire [3:0]  addr_idx    = addr[3:0];
   wire        wr_hit      = wr_done && addr_mapped && (addr_idx < `TCSPI_ADDR_LIN_B2); // RQ13
   wire        wr_cfg_pri  = wr_hit && (addr_idx == `TCSPI_ADDR_CFG_PRI); // RQ17
   wire        wr_cold     = wr_hit && ((addr_idx == `TCSPI_ADDR_COLD_MSB)
                                     || (addr_idx == `TCSPI_ADDR_COLD_LSB));

   // primary config fields
   wire cont_conv   = regs[`TCSPI_ADDR_CFG_PRI][`TCSPI_BIT_CONT_CONV]; // RQ18
   wire single_req  = regs[`TCSPI_ADDR_CFG_PRI][`TCSPI_BIT_SINGLE_REQ]; // RQ18
   wire cold_dis    = regs[`TCSPI_ADDR_CFG_PRI][`TCSPI_BIT_COLD_DIS]; // RQ18
   wire latch_mode  = regs[`TCSPI_ADDR_CFG_PRI][`TCSPI_BIT_FAULT_MODE]; // RQ18
   wire flag_clear  = wr_cfg_pri && lnk.rx_byte[`TCSPI_BIT_FLAG_CLEAR] && latch_mode; // RQ18

   // result-ready release on completed reads of the result or live cold bytes
   wire rd_lin  = (addr_idx >= `TCSPI_ADDR_LIN_B2) && (addr_idx <= `TCSPI_ADDR_LIN_B0);
   wire rd_cold = ((addr_idx == `TCSPI_ADDR_COLD_MSB) || (addr_idx == `TCSPI_ADDR_COLD_LSB))
                  && !cold_dis;
   wire ready_release = rd_done && addr_mapped && (rd_lin || rd_cold); // RQ16

   // hot result clamped to the limit on the side it left
   wire [23:0] lin_stored = !hot_out_of_range ? lin_result
                          : (lin_result[23] ? hot_limit_low : hot_limit_high); // RQ2

   // fault conditions; the two range bits are kept out of the pin
   wire [7:0] fault_now = {cold_out_of_range, hot_out_of_range, fault_cond}; // RQ1
   wire [5:0] pin_faults = regs[`TCSPI_ADDR_FLAGS][5:0] & ~regs[`TCSPI_ADDR_FMASK][5:0]; // RQ3

   // phase and address
   always_comb
   begin
      next_phase = phase;
      next_addr  = addr;
      if (!in_frame)
         next_phase = TCSPI_IDLE; // RQ4
      else if (frame_start)
         next_phase = TCSPI_ADDR; // RQ10
      else if (addr_done)
      begin
         next_phase = wr_mode ? TCSPI_WRITE : TCSPI_READ; // RQ10
         next_addr  = lnk.rx_byte[`TCSPI_ADDR_WIDTH-1:0];
      end
      else if (rd_done || wr_done)
         next_addr = addr + 7'h01; // RQ11
   end

   // interrupt mode holds flags until cleared; a new event beats the clear
   always_comb
   begin
      if (latch_mode)
         next_flags = fault_now | (regs[`TCSPI_ADDR_FLAGS] & ~{8{flag_clear}});
      else
         next_flags = fault_now;
   end

   // register file update
   always_comb
   begin
      for (int i = 0; i < `TCSPI_REG_COUNT; i++)
         next_regs[i] = regs[i];
      if (lin_result_valid)
      begin
         next_regs[`TCSPI_ADDR_LIN_B2] = lin_stored[23:16];
         next_regs[`TCSPI_ADDR_LIN_B1] = lin_stored[15:8];
         next_regs[`TCSPI_ADDR_LIN_B0] = lin_stored[7:0];
      end
      // host value kept while the internal sensor is off
      if (cold_result_valid && !cold_dis && !wr_cold)
      begin
         next_regs[`TCSPI_ADDR_COLD_MSB] = cold_result[15:8];
         next_regs[`TCSPI_ADDR_COLD_LSB] = cold_result[7:0];
      end
      if (frame_end)
         next_regs[`TCSPI_ADDR_CFG_PRI][`TCSPI_BIT_SINGLE_REQ] = 1'b0; // RQ19
      if (wr_hit)
         next_regs[addr_idx] = lnk.rx_byte; // RQ21
      // clear request acts once and never reads back
      if (wr_cfg_pri)
         next_regs[`TCSPI_ADDR_CFG_PRI][`TCSPI_BIT_FLAG_CLEAR] = 1'b0; // RQ18
      next_regs[`TCSPI_ADDR_FLAGS] = next_flags; // RQ1
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         sclk_prev <= 1'b1;
         cs_n_prev <= 1'b1;
         idle_high <= 1'b0;
         phase     <= TCSPI_IDLE;
         addr      <= 7'h00;
      end
      else
      begin
         sclk_prev <= sclk_s;
         cs_n_prev <= cs_n_s;
         if (frame_start)
            idle_high <= sclk_s; // RQ6
         phase <= next_phase;
         addr  <= next_addr;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < `TCSPI_REG_COUNT; i++)
            regs[i] <= RESET_VALS[i];
      end
      else
      begin
         for (int i = 0; i < `TCSPI_REG_COUNT; i++)
            regs[i] <= next_regs[i];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         result_ready_n       <= 1'b1;
         fault_n              <= 1'b1;
         single_convert_start <= 1'b0;
      end
      else
      begin
         // a new result in the release cycle keeps ready low
         if (lin_result_valid)
            result_ready_n <= 1'b0; // RQ15
         else if (ready_release)
            result_ready_n <= 1'b1; // RQ16
         fault_n              <= ~|pin_faults; // RQ3
         single_convert_start <= frame_end && single_req && !cont_conv; // RQ19
      end
   end

   assign sdo              = lnk.sdo_bit;
   assign sdo_oe_n         = !(in_frame && (phase == TCSPI_READ)); // RQ14
   assign config_primary   = regs[`TCSPI_ADDR_CFG_PRI];
   assign config_secondary = regs[`TCSPI_ADDR_CFG_SEC];
   assign fault_mask       = regs[`TCSPI_ADDR_FMASK];
endmodule

//--- tb/tcspi_port_properties.sv
// concurrent checks on the thermocouple serial port pins
module tcspi_port_checker
   import tcspi_pkg::*;
(
   input wire logic                   clk_sys,
   input wire logic                   resetn,
   input wire logic                   cs_n,
   input wire logic                   sdo_oe_n,
   input wire logic                   result_ready_n,
   input wire logic                   fault_n,
   input wire logic                   lin_result_valid,
   input wire logic [5:0]             fault_cond,
   input wire tcspi_pkg::tcspi_byte_t config_primary,
   input wire tcspi_pkg::tcspi_byte_t fault_mask,
   input wire logic                   single_convert_start
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   // five cycles covers the chip-select synchroniser
   idle_hiz_a: assert property (cs_n [*5] |-> sdo_oe_n)
      else $error("data output driven outside a frame");
   oe_start_a: assert property ($fell(sdo_oe_n) |-> !cs_n && $past(cs_n, 4) == 1'b0)
      else $error("data output enabled without an open frame");
   ready_set_a: assert property (lin_result_valid |=> !result_ready_n)
      else $error("ready not asserted after a new result");
   ready_cause_a: assert property ($fell(result_ready_n) |-> $past(lin_result_valid))
      else $error("ready asserted without a new result");
   ready_rel_a: assert property (
      $rose(result_ready_n) |-> !cs_n && !$past(lin_result_valid))
      else $error("ready released outside a read");
   one_pulse_a: assert property (single_convert_start |=> !single_convert_start)
      else $error("conversion start longer than one cycle");
   start_cause_a: assert property (single_convert_start |-> cs_n && !config_primary[7])
      else $error("conversion start outside normally-off frame end");
   // range flags have no path to the fault pin
   fault_quiet_a: assert property (
      (!config_primary[2] && (fault_cond & ~fault_mask[5:0]) == 6'h00) [*3] |-> fault_n)
      else $error("fault pin asserted without an unmasked condition");
   cover property (single_convert_start);
   cover property ($rose(result_ready_n));
   cover property ($fell(sdo_oe_n));
endmodule
bind tcspi_port tcspi_port_checker chk (.clk_sys, .resetn, .cs_n, .sdo_oe_n, .result_ready_n,
   .fault_n, .lin_result_valid, .fault_cond, .config_primary, .fault_mask, .single_convert_start);

//--- tb/tcspi_master.sv
// serial master model for the port's link pins
module tcspi_master
   import tcspi_pkg::*;
(
   input  wire logic clk_sys,
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic sdo,
   input  wire logic sdo_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   tcspi_byte_t tx[20];
   tcspi_byte_t rx[20];
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end
   // ten system cycles: half of an 80 ns link clock
   task automatic half();
      repeat (10) @(posedge clk_sys);
   endtask
   // whole bytes, then loose bits; pol is the idle clock level
   task automatic run(input int nb, input int extra, input logic pol);
      sclk <= pol;
      half();
      cs_n <= 1'b0;
      half();
      for (int i = 0; i < nb * 8 + extra; i++)
      begin
         sclk <= ~pol;
         sdi  <= tx[i / 8][7 - i % 8];
         half();
         sclk <= pol;
         rx[i / 8][7 - i % 8] = (sdo_oe_n === 1'b0) ? sdo : 1'bz;
         half();
      end
      cs_n <= 1'b1;
      sdi  <= ~sdi; // released line never shows a stale bit
      half();
   endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the thermocouple serial register port
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import tcspi_pkg::*;
   logic        clk_sys, resetn, sclk, cs_n, sdi, sdo, sdo_oe_n;
   logic        result_ready_n, fault_n, single_convert_start;
   logic        lin_result_valid, hot_out_of_range, cold_out_of_range;
   logic [23:0] lin_result, hot_limit_high, hot_limit_low;
   logic [5:0]  fault_cond;
   tcspi_byte_t config_primary, config_secondary, fault_mask;
   tcspi_byte_t model[16];
   int          error_cnt, n_tests, starts, cyc;
   tcspi_port uut (
      .clk_sys, .resetn, .sclk, .cs_n, .sdi, .sdo, .sdo_oe_n, .result_ready_n, .fault_n,
      .lin_result_valid, .lin_result, .hot_out_of_range, .hot_limit_high,
      .hot_limit_low, .cold_result_valid(1'b0), .cold_result(16'h0000),
      .cold_out_of_range, .fault_cond, .config_primary, .config_secondary, .fault_mask,
      .single_convert_start
   );
   tcspi_master m (.clk_sys, .sclk, .cs_n, .sdi, .sdo, .sdo_oe_n);
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // run is about 12500 cycles; ceiling leaves ample margin
   always @(posedge clk_sys)
   begin
      cyc++;
      if (single_convert_start === 1'b1)
         starts++;
      if (cyc == 40000)
      begin
         error_cnt++;
         test_done();
      end
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] want);
      n_tests++;
      if (seen !== want)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   task automatic rd_chk(input logic [6:0] a, input int n, input logic pol);
      logic [6:0] idx;
      m.tx[0] = {1'b0, a};
      m.run(n + 1, 0, pol);
      check(m.rx[0], 8'hZZ);
      for (int i = 0; i < n; i++)
      begin
         idx = a + 7'(i);
         check(m.rx[i + 1], (idx < 7'h10) ? model[idx[3:0]] : 8'hFF);
      end
   endtask
   // model follows whole bytes to writable places only
   task automatic wr(input logic [6:0] a, input int n, input int extra, input logic pol);
      logic [6:0] idx;
      m.tx[0] = {1'b1, a};
      m.run(n + 1, extra, pol);
      for (int i = 0; i <= n; i++)
         check(m.rx[i], 8'hZZ);
      for (int i = 0; i < n; i++)
      begin
         idx = a + 7'(i);
         if (idx < 7'h0C)
            model[idx[3:0]] = m.tx[i + 1];
      end
   endtask
   task automatic pulse(input logic [23:0] v);
      lin_result       <= v;
      lin_result_valid <= 1'b1;
      @(posedge clk_sys);
      lin_result_valid <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   initial
   begin
      resetn            = 1'b0;
      lin_result_valid  = 1'b0;
      lin_result        = 24'h000000;
      hot_out_of_range  = 1'b0;
      cold_out_of_range = 1'b0;
      hot_limit_high    = 24'h640000;
      hot_limit_low     = 24'hF06000;
      fault_cond        = 6'h00;
      model = '{8'h00, 8'h03, 8'hFF, 8'h7F, 8'hC0, 8'h7F, 8'hFF, 8'h80,
                8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd_chk(7'h00, 16, 1'b0);
      $display("test reset values done");
      m.tx[1] = 8'h5A;
      m.tx[2] = 8'h10;
      m.tx[3] = 8'h35;
      wr(7'h7F, 3, 0, 1'b1);
      check(config_primary, 8'h10);
      check(config_secondary, 8'h35);
      rd_chk(7'h7E, 4, 1'b1);
      $display("test wrap and polarity done");
      m.tx[1] = 8'h66;
      m.tx[2] = 8'h77;
      wr(7'h0B, 2, 0, 1'b0);
      m.tx[1] = 8'h11;
      m.tx[2] = 8'h22;
      wr(7'h03, 1, 4, 1'b0);
      rd_chk(7'h03, 10, 1'b0);
      $display("test read-only and loose bits done");
      pulse(24'h123400);
      check(result_ready_n, 1'b0);
      model[12] = 8'h12;
      model[13] = 8'h34;
      rd_chk(7'h0C, 3, 1'b0);
      check(result_ready_n, 1'b1);
      m.tx[1] = 8'h00;
      wr(7'h02, 1, 0, 1'b0);
      check(fault_mask, 8'h00);
      hot_out_of_range  <= 1'b1;
      cold_out_of_range <= 1'b1;
      pulse(24'h7F0000);
      check(fault_n, 1'b1);
      model[12] = 8'h64;
      model[13] = 8'h00;
      model[15] = 8'hC0;
      rd_chk(7'h0C, 4, 1'b0);
      fault_cond <= 6'h01;
      repeat (4) @(posedge clk_sys);
      check(fault_n, 1'b0);
      fault_cond <= 6'h00;
      $display("test result ready and range flags done");
      m.tx[1] = 8'h50;
      wr(7'h00, 1, 0, 1'b1);
      check(24'(starts), 24'h000001);
      m.tx[1] = 8'hC0;
      wr(7'h00, 1, 0, 1'b0);
      check(24'(starts), 24'h000001);
      model[0] = 8'h80;
      rd_chk(7'h00, 1, 1'b0);
      $display("test single conversion done");
      m.tx[1] = 8'h0C;
      wr(7'h00, 1, 0, 1'b0);
      pulse(24'h800000);
      fault_cond <= 6'h02;
      repeat (3) @(posedge clk_sys);
      fault_cond <= 6'h00;
      repeat (4) @(posedge clk_sys);
      check(fault_n, 1'b0);
      rd_chk(7'h0A, 2, 1'b0);
      check(result_ready_n, 1'b0);
      model[12] = 8'hF0;
      model[13] = 8'h60;
      model[15] = 8'hC2;
      rd_chk(7'h0C, 4, 1'b0);
      check(result_ready_n, 1'b1);
      m.tx[1] = 8'h0E;
      wr(7'h00, 1, 0, 1'b0);
      check(config_primary, 8'h0C);
      check(fault_n, 1'b1);
      model[0]  = 8'h0C;
      model[15] = 8'hC0;
      rd_chk(7'h0F, 1, 1'b0);
      $display("test sticky flags and cold disable done");
      test_done();
   end
endmodule
